/* File: hdl/afm_map.svh */
`ifndef AFM_MAP_SVH
`define AFM_MAP_SVH
// unmute delay: 200 us at 200 MHz
`define AFM_UNMUTE_US 200
`define AFM_CLK_MHZ 200
`define AFM_UNMUTE_CYC (`AFM_UNMUTE_US * `AFM_CLK_MHZ)
`define AFM_CNT_W 16
`define AFM_NUM_BRIDGES 8
`define AFM_SYNC_W 2
// bit positions inside the synchroniser word, detectors at the bottom
`define AFM_SENSE_W 7
`define AFM_POS_RN 7
`define AFM_POS_RP 8
`define AFM_POS_LN 9
`define AFM_POS_LP 10
`define AFM_POS_MUTE 11
`define AFM_POS_SHUTDOWN_N 12
`define AFM_SYNC_N 13
`endif

/* File: hdl/afm_pkg.sv */
package afm_pkg;
   // detector levels from the analog front end, all active high
   typedef struct packed {
      logic warnHot;      // above 135 C, stays set until below 120 C
      logic overTemp;     // above 150 C
      logic overCurrent;  // 5 A peak limit
      logic outShort;     // short at filtered output
      logic powerUv;      // power_stage_supply below threshold
      logic logicUv;      // logic_supply below threshold
      logic clockLoss;
   } afm_sense_s;
   typedef enum logic [1:0] {AFM_SLEEP, AFM_AWAKE, AFM_WAIT, AFM_RUN} afm_state_e;
   typedef logic [7:0] afm_bridge_t;
endpackage : afm_pkg

/* File: hdl/amp_fault_mute_control.sv */
`timescale 1ns/10ps
`include "afm_map.svh"
module amp_fault_mute_control (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic shutdown_n,
   input wire logic mute_n,
   input wire logic left_pwm_in_pos,
   input wire logic left_pwm_in_neg,
   input wire logic right_pwm_in_pos,
   input wire logic right_pwm_in_neg,
   input wire afm_pkg::afm_sense_s senseIn,
   output logic [`AFM_NUM_BRIDGES-1:0] bridgeEn,
   output logic [`AFM_NUM_BRIDGES-1:0] bridgeHigh,
   output logic thermal_warning_flag_n_o,
   output logic thermal_warning_flag_n_oe,
   output logic error_flag_n_o,
   output logic error_flag_n_oe,
   output logic sleepMode
);
   localparam int UNMUTE_CYC = `AFM_UNMUTE_CYC;

   // ==========================================================
   // input synchronisers
   // ==========================================================
   // every control pin and detector is asynchronous to sys_clk
   // trade-off: two flops add two clocks of fault latency, far below any thermal time
   localparam int NSYNC = `AFM_SYNC_N;
   logic [NSYNC-1:0] syncA_q, syncA_d, syncB_q, syncB_d;
   logic [NSYNC-1:0] rawIn;
   assign rawIn = {shutdown_n, mute_n, left_pwm_in_pos, left_pwm_in_neg,
                   right_pwm_in_pos, right_pwm_in_neg, senseIn};
   always_comb begin
      syncA_d = rawIn;
      syncB_d = syncA_q;
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else begin
         syncA_q <= syncA_d;
         syncB_q <= syncB_d;
      end
   end
   logic stdnS, muteS, lp, ln, rp, rn;
   afm_pkg::afm_sense_s senseS;
   assign stdnS = syncB_q[`AFM_POS_SHUTDOWN_N];
   assign muteS = syncB_q[`AFM_POS_MUTE];
   assign lp = syncB_q[`AFM_POS_LP];
   assign ln = syncB_q[`AFM_POS_LN];
   assign rp = syncB_q[`AFM_POS_RP];
   assign rn = syncB_q[`AFM_POS_RN];
   assign senseS = afm_pkg::afm_sense_s'(syncB_q[`AFM_SENSE_W-1:0]);

   // ==========================================================
   // fault latch and control sequence
   // ==========================================================
   logic faultNow;
   // warnHot is left out: a warning alone never stops the stage
   assign faultNow = senseS.overTemp | senseS.overCurrent | senseS.outShort |
                     senseS.powerUv | senseS.logicUv | senseS.clockLoss;

   logic errLatch_q, errLatch_d, muteLow_q, muteLow_d, warn_q, warn_d;
   logic [`AFM_CNT_W-1:0] cnt_q, cnt_d;
   afm_pkg::afm_state_e state_q, state_d;

   always_comb begin
      errLatch_d = errLatch_q;
      muteLow_d = muteLow_q;
      cnt_d = cnt_q;
      state_d = state_q;
      warn_d = senseS.warnHot;
      if (!muteS)
         muteLow_d = 1'b1;
      // clear on mute rising after a low; a live fault sets again at once
      if (muteS && muteLow_q) begin
         muteLow_d = 1'b0;
         errLatch_d = 1'b0;
      end
      if (faultNow)
         errLatch_d = 1'b1;
      case (state_q)
         afm_pkg::AFM_SLEEP: if (stdnS) state_d = afm_pkg::AFM_AWAKE;
         afm_pkg::AFM_AWAKE: begin
            if (muteS && !errLatch_d) begin
               state_d = afm_pkg::AFM_WAIT;
               cnt_d = '0;
            end
         end
         afm_pkg::AFM_WAIT: begin
            // limitation: a fault or mute low during the wait restarts the full count
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == `AFM_CNT_W'(UNMUTE_CYC - 1)) state_d = afm_pkg::AFM_RUN;
         end
         afm_pkg::AFM_RUN: ;
         default: state_d = afm_pkg::AFM_SLEEP;
      endcase
      if (state_q != afm_pkg::AFM_SLEEP && (!muteS || errLatch_d))
         state_d = afm_pkg::AFM_AWAKE;
      if (!stdnS)
         state_d = afm_pkg::AFM_SLEEP;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         errLatch_q <= 1'b0;
         muteLow_q <= 1'b0;
         warn_q <= 1'b0;
         cnt_q <= '0;
         state_q <= afm_pkg::AFM_SLEEP;
      end else begin
         errLatch_q <= errLatch_d;
         muteLow_q <= muteLow_d;
         warn_q <= warn_d;
         cnt_q <= cnt_d;
         state_q <= state_d;
      end
   end

   // ==========================================================
   // bridge drive and flags
   // ==========================================================
   logic run;
   afm_pkg::afm_bridge_t en_d, hi_d, en_q, hi_q;
   // faultNow gates at once, without waiting a clock for the latch
   assign run = (state_q == afm_pkg::AFM_RUN) && !errLatch_q && !faultNow;
   always_comb begin
      en_d = {`AFM_NUM_BRIDGES{run}};
      hi_d = run ? {rp, rp, rn, rn, lp, lp, ln, ln} : '0;
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         en_q <= '0;
         hi_q <= '0;
      end else begin
         en_q <= en_d;
         hi_q <= hi_d;
      end
   end
   assign bridgeEn = en_q;
   assign bridgeHigh = hi_q;
   assign sleepMode = (state_q == afm_pkg::AFM_SLEEP);
   assign thermal_warning_flag_n_o = 1'b0;
   assign thermal_warning_flag_n_oe = warn_q;
   assign error_flag_n_o = 1'b0;
   assign error_flag_n_oe = errLatch_q;

   // ==========================================================
   // checks
   // ==========================================================
   a_fault_latches: assert property (@(posedge sys_clk) disable iff (sys_rst)
      faultNow |=> error_flag_n_oe) else $error("fault not latched");
   a_fault_stops: assert property (@(posedge sys_clk) disable iff (sys_rst)
      faultNow |=> bridgeEn == '0) else $error("bridges on during fault");
   a_error_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
      error_flag_n_oe && muteS && $past(muteS) |=> error_flag_n_oe) else $error("error cleared without mute");
   a_sleep_hiz: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !stdnS |=> sleepMode ##1 bridgeEn == '0) else $error("bridges on in sleep");
   a_mute_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !muteS |=> ##1 bridgeEn == '0) else $error("bridges on while muted");
   a_unmute_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == afm_pkg::AFM_AWAKE ##1 state_q == afm_pkg::AFM_WAIT |-> bridgeEn == '0 [*8])
      else $error("bridges on early");
   a_warn_no_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == afm_pkg::AFM_RUN && !faultNow && !errLatch_q && senseS.warnHot
      |=> bridgeEn != '0) else $error("warning stopped stage");
   a_warn_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
      senseS.warnHot |=> thermal_warning_flag_n_oe) else $error("warning flag missed");
   a_flag_opendrain: assert property (@(posedge sys_clk)
      !error_flag_n_o && !thermal_warning_flag_n_o) else $error("flag driven high");
   a_err_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(error_flag_n_oe) |-> $past(muteS) && !$past(faultNow)) else $error("error released early");
   a_err_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(error_flag_n_oe) |-> $past(faultNow)) else $error("error without fault");
   a_warn_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !senseS.warnHot |=> !thermal_warning_flag_n_oe) else $error("warning flag stuck");
   a_warn_no_error: assert property (@(posedge sys_clk) disable iff (sys_rst)
      senseS.warnHot && !faultNow && !errLatch_q |=> !error_flag_n_oe) else $error("warning latched error");
   a_supply_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
      senseS.powerUv || senseS.logicUv |=> bridgeEn == '0 && error_flag_n_oe) else $error("supply fault ignored");

   // ==========================================================
   // sequencing and bridge group checks
   // ==========================================================
   a_powerup_hiz: assert property (@(posedge sys_clk)
      sys_rst |=> bridgeEn == '0 && sleepMode && !error_flag_n_oe) else $error("stage on at power-up");
   a_wake_hiz: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == afm_pkg::AFM_AWAKE |=> bridgeEn == '0) else $error("stage on before unmute");
   a_run_needs_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bridgeEn != '0 |-> $past(stdnS, 2)) else $error("stage on without wake");
   a_run_enables: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == afm_pkg::AFM_RUN && !error_flag_n_oe && !faultNow |=> bridgeEn == '1) else $error("stage not on");
   a_unmute_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == afm_pkg::AFM_WAIT |-> cnt_q < `AFM_CNT_W'(UNMUTE_CYC)) else $error("unmute count overrun");
   a_bridges_equal: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bridgeEn == '0 || bridgeEn == '1) else $error("bridges split");
   a_high_gated: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bridgeHigh & ~bridgeEn) == '0) else $error("level on disabled bridge");
endmodule : amp_fault_mute_control

/* File: tb/afm_modulator_model.sv */
`timescale 1ns/10ps
// ==========
// modulator and flag pull-ups
module afm_modulator_model (
   input wire logic sys_clk,
   input wire logic errOe,
   input wire logic warnOe,
   output logic [6:0] phase,
   output logic leftPos,
   output logic leftNeg,
   output logic rightPos,
   output logic rightNeg,
   output logic errWire,
   output logic warnWire
);
   initial phase = 7'h00;
   // free-running so the stage never sees a stuck-high input
   always @(posedge sys_clk) phase <= phase + 7'h01;
   assign leftPos = phase[5];
   assign leftNeg = ~phase[5];
   assign rightPos = phase[6];
   assign rightNeg = ~phase[6];
   // external pull-ups, open-drain pulls low only
   assign errWire = errOe ? 1'b0 : 1'b1;
   assign warnWire = warnOe ? 1'b0 : 1'b1;
endmodule : afm_modulator_model

/* File: tb/amp_fault_mute_control_test.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] %0t mismatch", $time); end end
module amp_fault_mute_control_test;
   logic sysClk = 1'b0, sysRst = 1'b1, shutdownN = 1'b0, muteN = 1'b0;
   logic lp, ln, rp, rn, errOe, warnOe, errW, warnW, eo, wo, sleepMode;
   logic [6:0] phase;
   logic [7:0] bridgeEn, bridgeHigh;
   afm_pkg::afm_sense_s sense = '0;
   int miscompares = 0, samplesChecked = 0;
   initial forever #2.5 sysClk = ~sysClk;
   amp_fault_mute_control uut (.sys_clk(sysClk), .sys_rst(sysRst), .shutdown_n(shutdownN), .mute_n(muteN),
      .left_pwm_in_pos(lp), .left_pwm_in_neg(ln), .right_pwm_in_pos(rp), .right_pwm_in_neg(rn),
      .senseIn(sense), .bridgeEn(bridgeEn), .bridgeHigh(bridgeHigh), .thermal_warning_flag_n_o(wo),
      .thermal_warning_flag_n_oe(warnOe), .error_flag_n_o(eo), .error_flag_n_oe(errOe), .sleepMode(sleepMode));
   afm_modulator_model partner (.sys_clk(sysClk), .errOe(errOe), .warnOe(warnOe), .phase(phase),
      .leftPos(lp), .leftNeg(ln), .rightPos(rp), .rightNeg(rn), .errWire(errW), .warnWire(warnW));
   // ==========
   // helpers
   task cyc(input int n);
      repeat (n) @(posedge sysClk);
      #1;
   endtask : cyc
   task test_done;
      $display("checked %0d, mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task wait_phase;
      int k;
      for (k = 0; k < 70 && phase[4:0] !== 5'h10; k++) cyc(1);
      if (k == 70) begin miscompares++; $display("[ERR] %0t phase wait timed out", $time); test_done(); end
   endtask : wait_phase
   task toggle_mute;
      muteN = 1'b0;
      cyc(5);
      muteN = 1'b1;
      cyc(6);
   endtask : toggle_mute
   // ==========
   // scenarios
   task test_sleep_wake;
      `CHK(sleepMode, 1'b1)
      `CHK(bridgeEn, 8'h00)
      shutdownN = 1'b1;
      cyc(6);
      `CHK(sleepMode, 1'b0)
      `CHK(bridgeEn, 8'h00)
      $display("sleep/wake done");
   endtask : test_sleep_wake
   task test_unmute;
      int k;
      muteN = 1'b1;
      cyc(39990);
      `CHK(bridgeEn, 8'h00)
      for (k = 0; k < 200 && bridgeEn !== 8'hff; k++) cyc(1);
      `CHK(bridgeEn, 8'hff)
      repeat (2) begin
         wait_phase();
         `CHK(bridgeHigh, {{2{phase[6]}}, {2{~phase[6]}}, {2{phase[5]}}, {2{~phase[5]}}})
         cyc(32);
      end
      $display("unmute done");
   endtask : test_unmute
   task test_warning;
      sense.warnHot = 1'b1;
      cyc(6);
      `CHK(warnW, 1'b0)
      `CHK(wo, 1'b0)
      `CHK(bridgeEn, 8'hff)
      `CHK(errW, 1'b1)
      sense.warnHot = 1'b0;
      cyc(6);
      `CHK(warnW, 1'b1)
      $display("warning done");
   endtask : test_warning
   task test_warn_mute;
      int k;
      sense.warnHot = 1'b1;
      for (k = 0; k < 20; k++) begin
         muteN = warnW;
         cyc(1);
      end
      `CHK(warnW, 1'b0)
      `CHK(bridgeEn, 8'h00)
      `CHK(errW, 1'b1)
      sense.warnHot = 1'b0;
      for (k = 0; k < 20; k++) begin
         muteN = warnW;
         cyc(1);
      end
      `CHK(warnW, 1'b1)
      `CHK(errW, 1'b1)
      `CHK(sleepMode, 1'b0)
      $display("warning feedback done");
   endtask : test_warn_mute
   task test_faults;
      // one pass per latched fault source, the live fault blocks the clear
      for (int i = 0; i < 6; i++) begin
         sense = afm_pkg::afm_sense_s'(7'h01 << i);
         cyc(6);
         `CHK(errW, 1'b0)
         `CHK(eo, 1'b0)
         `CHK(bridgeEn, 8'h00)
         toggle_mute();
         `CHK(errW, 1'b0)
         sense = '0;
         cyc(6);
         `CHK(errW, 1'b0)
         toggle_mute();
         `CHK(errW, 1'b1)
      end
      muteN = 1'b0;
      cyc(2);
      shutdownN = 1'b0;
      cyc(6);
      `CHK(sleepMode, 1'b1)
      $display("faults done");
   endtask : test_faults
   initial begin
      cyc(8);
      sysRst = 1'b0;
      cyc(3);
      test_sleep_wake();
      test_unmute();
      test_warning();
      test_warn_mute();
      test_faults();
      test_done();
   end
endmodule : amp_fault_mute_control_test
